// file: rtl/eag_top.sv
// Effective address generator: operand byte sequencer and adder.
// Assumes the fetch unit advances pc per byte taken, so at the
// calculation step pc addresses the next instruction.
`include "eag_regs.svh"
`default_nettype none
module eag_top (
	input wire logic clk,
	input wire logic reset,
	input wire logic ce,
	input wire logic start,
	input wire eag_pkg::eag_mode_type mode,
	input wire logic branch_cond,
	input wire logic in_valid,
	input wire logic [7:0] in_byte,
	output logic in_ready,
	output logic rd_req,
	output logic [15:0] rd_addr,
	input wire logic rd_ack,
	input wire logic [7:0] rd_data,
	input wire logic [15:0] pc,
	input wire logic [15:0] x_reg,
	input wire logic [15:0] y_reg,
	input wire logic [15:0] u_reg,
	input wire logic [15:0] s_reg,
	input wire logic [7:0] a_reg,
	input wire logic [7:0] b_reg,
	input wire logic [7:0] direct_page_register,
	output logic busy,
	output logic done,
	output logic [15:0] ea,
	output logic [15:0] operand,
	output logic pc_we,
	output logic [15:0] pc_value,
	output logic ptr_we,
	output logic [1:0] ptr_sel,
	output logic [15:0] ptr_value,
	output logic idx_bad,
	output logic [3:0] pair_src,
	output logic [3:0] pair_dst,
	output logic pair_bad,
	output logic [7:0] stack_mask,
	output logic [3:0] stack_bytes
);
	import eag_pkg::*;

	eag_state_type state_r, state_nxt;
	eag_mode_type mode_r;
	logic [1:0] cnt_r;
	logic pb_phase_r;
	logic [7:0] pb_r;
	logic [15:0] acc_r;
	logic [7:0] ind_hi_r;
	logic rd_req_r;
	logic [15:0] rd_addr_r;
	logic done_r, pc_we_r, ptr_we_r, idx_bad_r, pair_bad_r;
	logic [15:0] ea_r, operand_r, pc_value_r, ptr_value_r;
	logic [1:0] ptr_sel_r;
	logic [3:0] pair_src_r, pair_dst_r, stack_bytes_r;
	logic [7:0] stack_mask_r;

	eag_pb_if pb ();
	eag_pb_decode u_dec (
		.pb(pb.dec)
	);

	function automatic logic [15:0] offset_of(input eag_kind_type k,
		input logic [7:0] p, input logic [15:0] c,
		input logic [7:0] a, input logic [7:0] b);
		case (k)
			EAG_K_OFF5: return 16'(signed'(p[`EAG_PB_OFF5])); // RQ8
			EAG_K_OFF8, EAG_K_PC8:
				return 16'(signed'(c[`EAG_BYTE_LO])); // RQ6
			EAG_K_OFF16, EAG_K_PC16: return c; // RQ15
			EAG_K_ACCA: return 16'(signed'(a)); // RQ9
			EAG_K_ACCB: return 16'(signed'(b)); // RQ9
			EAG_K_ACCD: return {a, b}; // RQ9
			EAG_K_DEC1: return 16'h0000 - `EAG_STEP1; // RQ12
			EAG_K_DEC2: return 16'h0000 - `EAG_STEP2; // RQ12
			default: return 16'h0000;
		endcase
	endfunction : offset_of

	function automatic logic code_ok(input logic [3:0] c);
		return (c <= `EAG_RC_PC) || (c >= `EAG_RC_A && c <= `EAG_RC_DP);
	endfunction : code_ok

	// Sixteen-bit registers cost two stack bytes each
	function automatic logic [3:0] stack_count(input logic [7:0] m);
		logic [3:0] n;
		n = 4'h0;
		for (int i = 0; i < 8; i++)
			n = n + {3'h0, m[i]};
		n = n + {3'h0, m[`EAG_SB_PC]} + {3'h0, m[`EAG_SB_SU]} +
			{3'h0, m[`EAG_SB_Y]} + {3'h0, m[`EAG_SB_X]}; // RQ3
		return n;
	endfunction : stack_count

	wire logic take_byte;
	wire logic take_pb;
	wire logic [15:0] ptr_cur;
	wire logic [15:0] base;
	wire logic [15:0] off_val;
	wire logic [15:0] idx_ea;
	wire logic [15:0] step_val;
	wire logic [15:0] step_ptr;
	wire logic is_inc, is_dec;
	wire logic [15:0] acc_shift;
	wire logic [1:0] mode_bytes;

	assign take_byte = (state_r == EAG_S_FETCH) & in_valid;
	assign take_pb = take_byte & pb_phase_r;
	// Decoder sees the live byte so its offset count is known at once
	assign pb.postbyte = pb_phase_r ? in_byte : pb_r;
	assign acc_shift = {acc_r[`EAG_BYTE_LO], in_byte};
	assign mode_bytes = (mode == EAG_M_IMM16 || mode == EAG_M_EXT ||
		mode == EAG_M_BR16) ? 2'h2 : 2'h1; // RQ1
	assign ptr_cur = (pb.rsel == `EAG_PTR_X) ? x_reg :
		(pb.rsel == `EAG_PTR_Y) ? y_reg :
		(pb.rsel == `EAG_PTR_U) ? u_reg : s_reg; // RQ19
	assign base = pb.pc_rel ? pc : ptr_cur; // RQ15
	assign off_val = offset_of(pb.kind, pb_r, acc_r, a_reg, b_reg);
	// Extended indirect uses the fetched word as its base
	assign idx_ea = (pb.kind == EAG_K_EXTI) ? acc_r :
		16'(base + off_val); // RQ20
	assign is_inc = (pb.kind == EAG_K_INC1) || (pb.kind == EAG_K_INC2);
	assign is_dec = (pb.kind == EAG_K_DEC1) || (pb.kind == EAG_K_DEC2);
	assign step_val = (pb.kind == EAG_K_INC2) ? `EAG_STEP2 : `EAG_STEP1;
	assign step_ptr = is_inc ? 16'(ptr_cur + step_val) : idx_ea; // RQ11

	always_comb begin
		state_nxt = state_r;
		case (state_r)
			EAG_S_IDLE: begin
				if (start && mode != EAG_M_INH)
					state_nxt = EAG_S_FETCH;
			end
			EAG_S_FETCH: begin
				if (take_pb)
					state_nxt = (pb.nbytes == 2'h0) ? EAG_S_CALC : EAG_S_FETCH;
				else if (take_byte && cnt_r == 2'h1)
					state_nxt = EAG_S_CALC;
			end
			EAG_S_CALC: begin
				if (mode_r == EAG_M_IDX && pb.indirect)
					state_nxt = EAG_S_IND_HI; // RQ13
				else
					state_nxt = EAG_S_IDLE;
			end
			EAG_S_IND_HI: begin
				if (rd_ack)
					state_nxt = EAG_S_IND_LO;
			end
			EAG_S_IND_LO: begin
				if (rd_ack)
					state_nxt = EAG_S_IDLE;
			end
			default: state_nxt = EAG_S_IDLE;
		endcase
	end

	// Sequencer state
	always_ff @(posedge clk) begin
		if (reset) begin
			state_r <= EAG_S_IDLE;
			mode_r <= EAG_M_INH;
			cnt_r <= 2'h0;
			pb_phase_r <= 1'b0;
			pb_r <= 8'h00;
			acc_r <= 16'h0000;
		end else if (ce) begin
			state_r <= state_nxt;
			if (state_r == EAG_S_IDLE && start) begin
				mode_r <= mode;
				cnt_r <= mode_bytes;
				pb_phase_r <= (mode == EAG_M_IDX);
			end
			if (take_pb) begin
				pb_r <= in_byte;
				pb_phase_r <= 1'b0;
				cnt_r <= pb.nbytes; // RQ8
			end else if (take_byte) begin
				acc_r <= acc_shift; // RQ1
				cnt_r <= cnt_r - 2'h1;
			end
		end
	end

	// Indirect pointer read, two bytes high first
	always_ff @(posedge clk) begin
		if (reset) begin
			rd_req_r <= 1'b0;
			rd_addr_r <= 16'h0000;
			ind_hi_r <= 8'h00;
		end else if (ce) begin
			if (state_r == EAG_S_CALC && mode_r == EAG_M_IDX &&
				pb.indirect) begin
				rd_req_r <= 1'b1;
				rd_addr_r <= idx_ea; // RQ14
			end else if (state_r == EAG_S_IND_HI && rd_ack) begin
				ind_hi_r <= rd_data;
				rd_addr_r <= 16'(rd_addr_r + `EAG_STEP1); // RQ20
			end else if (state_r == EAG_S_IND_LO && rd_ack) begin
				rd_req_r <= 1'b0;
			end
		end
	end

	// Results; done and write strobes are one-cycle pulses
	always_ff @(posedge clk) begin
		if (reset) begin
			done_r <= 1'b0;
			pc_we_r <= 1'b0;
			ptr_we_r <= 1'b0;
		end else if (ce) begin
			done_r <= (state_r == EAG_S_IDLE && start &&
				mode == EAG_M_INH) ||
				(state_r == EAG_S_CALC &&
				!(mode_r == EAG_M_IDX && pb.indirect)) ||
				(state_r == EAG_S_IND_LO && rd_ack);
			pc_we_r <= (state_r == EAG_S_CALC) && branch_cond &&
				(mode_r == EAG_M_BR8 || mode_r == EAG_M_BR16); // RQ16
			ptr_we_r <= (state_r == EAG_S_CALC) &&
				(mode_r == EAG_M_IDX) && (is_inc || is_dec); // RQ6
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			ea_r <= 16'h0000;
			operand_r <= 16'h0000;
			pc_value_r <= 16'h0000;
			ptr_value_r <= 16'h0000;
			ptr_sel_r <= `EAG_PTR_X;
			idx_bad_r <= 1'b0;
		end else if (ce) begin
			if (state_r == EAG_S_CALC) begin
				case (mode_r)
					EAG_M_IMM8: operand_r <= {8'h00, acc_r[`EAG_BYTE_LO]}; // RQ1
					EAG_M_IMM16: operand_r <= acc_r; // RQ1
					EAG_M_EXT: ea_r <= acc_r; // RQ4
					EAG_M_DIR:
						ea_r <= {direct_page_register, acc_r[`EAG_BYTE_LO]}; // RQ5
					EAG_M_BR8: pc_value_r <=
						16'(pc + 16'(signed'(acc_r[`EAG_BYTE_LO]))); // RQ17
					EAG_M_BR16: pc_value_r <= 16'(pc + acc_r); // RQ18
					EAG_M_IDX: begin
						ea_r <= is_inc ? ptr_cur : idx_ea; // RQ11 RQ12
						ptr_value_r <= step_ptr; // RQ12
						ptr_sel_r <= pb.rsel;
						idx_bad_r <= pb.bad;
					end
					default: ea_r <= ea_r;
				endcase
			end else if (state_r == EAG_S_IND_LO && rd_ack) begin
				ea_r <= {ind_hi_r, rd_data}; // RQ13
			end
		end
	end

	// Register-select postbytes
	always_ff @(posedge clk) begin
		if (reset) begin
			pair_src_r <= 4'h0;
			pair_dst_r <= 4'h0;
			pair_bad_r <= 1'b0;
			stack_mask_r <= 8'h00;
			stack_bytes_r <= 4'h0;
		end else if (ce && state_r == EAG_S_CALC) begin
			if (mode_r == EAG_M_REGPAIR) begin
				pair_src_r <= acc_r[`EAG_NIB_HI]; // RQ2
				pair_dst_r <= acc_r[`EAG_NIB_LO]; // RQ2
				// Undefined codes are flagged, not repaired
				pair_bad_r <= !code_ok(acc_r[`EAG_NIB_HI]) ||
					!code_ok(acc_r[`EAG_NIB_LO]); // RQ2
			end
			if (mode_r == EAG_M_STACK) begin
				stack_mask_r <= acc_r[`EAG_BYTE_LO]; // RQ3
				stack_bytes_r <= stack_count(acc_r[`EAG_BYTE_LO]); // RQ3
			end
		end
	end

	assign in_ready = (state_r == EAG_S_FETCH);
	assign busy = (state_r != EAG_S_IDLE);
	assign rd_req = rd_req_r;
	assign rd_addr = rd_addr_r;
	assign done = done_r;
	assign ea = ea_r;
	assign operand = operand_r;
	assign pc_we = pc_we_r;
	assign pc_value = pc_value_r;
	assign ptr_we = ptr_we_r;
	assign ptr_sel = ptr_sel_r;
	assign ptr_value = ptr_value_r;
	assign idx_bad = idx_bad_r;
	assign pair_src = pair_src_r;
	assign pair_dst = pair_dst_r;
	assign pair_bad = pair_bad_r;
	assign stack_mask = stack_mask_r;
	assign stack_bytes = stack_bytes_r;
endmodule : eag_top
`default_nettype wire

// file: rtl/eag_regs.svh
// Named constants of the effective address generator.
// Assumes inclusion by the design modules only.
// Summary of operation
// (RQ1) Immediate operand: one or two following bytes
// (RQ2) Swap/copy postbyte: high nibble source, low destination
// (RQ3) Push/restore postbyte: one bit per register
// (RQ4) Extended: next two bytes are the address
// (RQ5) Direct: page register high, next byte low
// (RQ6) Constant offset added, pointer left unchanged
// (RQ7) Constant-offset postbyte codes, 5-bit indirect falls back
// (RQ8) 5-bit offset in postbyte, others follow it
// (RQ9) Accumulator offset added signed, registers unchanged
// (RQ10) Auto-step codes; indirect only for step two
// (RQ11) Auto-increment: use pointer, then step it
// (RQ12) Auto-decrement: step pointer, then use it
// (RQ13) Indirection reads two bytes at base plus offset
// (RQ14) Postbyte 10011111 reads pointer after postbyte
// (RQ15) Program-counter relative with 8 or 16-bit offset
// (RQ16) Taken branch loads counter plus offset
// (RQ17) Short branch: signed 8-bit displacement
// (RQ18) Long branch: signed 16-bit displacement
// (RQ19) Two-bit field picks one of four pointers
// (RQ20) Address sums wrap modulo 65536
`ifndef EAG_REGS_SVH
`define EAG_REGS_SVH

`define EAG_PTR_X 2'h0
`define EAG_PTR_Y 2'h1
`define EAG_PTR_U 2'h2
`define EAG_PTR_S 2'h3

`define EAG_RC_PC 4'h5
`define EAG_RC_A 4'h8
`define EAG_RC_DP 4'hb

`define EAG_SB_PC 7
`define EAG_SB_SU 6
`define EAG_SB_Y 5
`define EAG_SB_X 4

`define EAG_IX_INC1 4'h0
`define EAG_IX_INC2 4'h1
`define EAG_IX_DEC1 4'h2
`define EAG_IX_DEC2 4'h3
`define EAG_IX_ZERO 4'h4
`define EAG_IX_ACCB 4'h5
`define EAG_IX_ACCA 4'h6
`define EAG_IX_OFF8 4'h8
`define EAG_IX_OFF16 4'h9
`define EAG_IX_ACCD 4'hb
`define EAG_IX_PC8 4'hc
`define EAG_IX_PC16 4'hd
`define EAG_PB_EXTIND 8'h9f

`define EAG_PB_LONG 7
`define EAG_PB_IND 4
`define EAG_PB_RR 6:5
`define EAG_PB_CODE 3:0
`define EAG_PB_OFF5 4:0
`define EAG_NIB_HI 7:4
`define EAG_NIB_LO 3:0
`define EAG_BYTE_LO 7:0
`define EAG_STEP1 16'h0001
`define EAG_STEP2 16'h0002

`endif

// file: rtl/eag_pkg.sv
// Types shared by the effective address generator modules.
// Assumes nothing beyond the constants header.
`default_nettype none
package eag_pkg;
	typedef enum logic [3:0] {
		EAG_M_INH = 4'h0, EAG_M_IMM8 = 4'h1, EAG_M_IMM16 = 4'h2,
		EAG_M_EXT = 4'h3, EAG_M_DIR = 4'h4, EAG_M_IDX = 4'h5,
		EAG_M_BR8 = 4'h6, EAG_M_BR16 = 4'h7, EAG_M_REGPAIR = 4'h8,
		EAG_M_STACK = 4'h9
	} eag_mode_type;
	typedef enum logic [3:0] {
		EAG_K_NONE = 4'h0, EAG_K_OFF5 = 4'h1, EAG_K_OFF8 = 4'h2,
		EAG_K_OFF16 = 4'h3, EAG_K_ACCA = 4'h4, EAG_K_ACCB = 4'h5,
		EAG_K_ACCD = 4'h6, EAG_K_INC1 = 4'h7, EAG_K_INC2 = 4'h8,
		EAG_K_DEC1 = 4'h9, EAG_K_DEC2 = 4'ha, EAG_K_PC8 = 4'hb,
		EAG_K_PC16 = 4'hc, EAG_K_EXTI = 4'hd
	} eag_kind_type;
	typedef enum logic [2:0] {
		EAG_S_IDLE = 3'h0, EAG_S_FETCH = 3'h1, EAG_S_CALC = 3'h2,
		EAG_S_IND_HI = 3'h3, EAG_S_IND_LO = 3'h4
	} eag_state_type;
endpackage : eag_pkg
`default_nettype wire

// file: rtl/eag_pb_if.sv
// Carrier between the sequencer and the indexed postbyte decoder.
// Assumes one instance per sequencer.
`default_nettype none
interface eag_pb_if;
	import eag_pkg::*;
	logic [7:0] postbyte;
	eag_kind_type kind;
	logic indirect;
	logic pc_rel;
	logic [1:0] nbytes;
	logic [1:0] rsel;
	logic bad;
	modport dec (input postbyte, output kind, indirect, pc_rel, nbytes,
		rsel, bad);
	modport use_side (output postbyte, input kind, indirect, pc_rel,
		nbytes, rsel, bad);
endinterface : eag_pb_if
`default_nettype wire

// file: rtl/eag_pb_decode.sv
// Indexed postbyte decoder, purely combinational.
// Assumes the postbyte is stable while its results are used.
`include "eag_regs.svh"
`default_nettype none
module eag_pb_decode (
	eag_pb_if.dec pb
);
	import eag_pkg::*;

	function automatic eag_kind_type kind_of(input logic [7:0] p);
		if (!p[`EAG_PB_LONG])
			return EAG_K_OFF5; // RQ7
		if (p == `EAG_PB_EXTIND)
			return EAG_K_EXTI; // RQ14
		case (p[`EAG_PB_CODE])
			`EAG_IX_INC1: return EAG_K_INC1; // RQ10
			`EAG_IX_INC2: return EAG_K_INC2; // RQ10
			`EAG_IX_DEC1: return EAG_K_DEC1; // RQ10
			`EAG_IX_DEC2: return EAG_K_DEC2; // RQ10
			`EAG_IX_ZERO: return EAG_K_NONE; // RQ7
			`EAG_IX_ACCB: return EAG_K_ACCB; // RQ9
			`EAG_IX_ACCA: return EAG_K_ACCA; // RQ9
			`EAG_IX_ACCD: return EAG_K_ACCD; // RQ9
			`EAG_IX_OFF8: return EAG_K_OFF8; // RQ7
			`EAG_IX_OFF16: return EAG_K_OFF16; // RQ7
			`EAG_IX_PC8: return EAG_K_PC8; // RQ15
			`EAG_IX_PC16: return EAG_K_PC16; // RQ15
			default: return EAG_K_NONE;
		endcase
	endfunction : kind_of

	wire logic long_form;
	wire logic code_known;
	wire logic step_one;
	assign long_form = pb.postbyte[`EAG_PB_LONG];
	assign pb.kind = kind_of(pb.postbyte);
	// 5-bit form has no indirect variant
	assign pb.indirect = long_form & pb.postbyte[`EAG_PB_IND]; // RQ7
	assign pb.pc_rel = (pb.kind == EAG_K_PC8) ||
		(pb.kind == EAG_K_PC16); // RQ19
	assign pb.rsel = pb.postbyte[`EAG_PB_RR]; // RQ19
	assign pb.nbytes = (pb.kind == EAG_K_OFF8 || pb.kind == EAG_K_PC8) ?
		2'h1 : (pb.kind == EAG_K_OFF16 || pb.kind == EAG_K_PC16 ||
		pb.kind == EAG_K_EXTI) ? 2'h2 : 2'h0; // RQ8
	assign code_known = (pb.kind != EAG_K_NONE) ||
		(pb.postbyte[`EAG_PB_CODE] == `EAG_IX_ZERO);
	assign step_one = (pb.kind == EAG_K_INC1) || (pb.kind == EAG_K_DEC1);
	// Step-by-one has no indirect form
	assign pb.bad = long_form &
		(!code_known | (pb.indirect & step_one)); // RQ10
endmodule : eag_pb_decode
`default_nettype wire

// file: verification/eag_properties.sv
// Assertion checker for the effective address generator top.
// Assumes pc and the register file stay steady during a request.
`default_nettype none
module eag_props (
	input wire logic clk,
	input wire logic reset,
	input wire logic ce,
	input wire logic start,
	input wire eag_pkg::eag_mode_type mode,
	input wire logic branch_cond,
	input wire logic in_valid,
	input wire logic [7:0] in_byte,
	input wire logic in_ready,
	input wire logic rd_req,
	input wire logic [15:0] rd_addr,
	input wire logic rd_ack,
	input wire logic [7:0] rd_data,
	input wire logic [15:0] pc,
	input wire logic [7:0] direct_page_register,
	input wire logic busy,
	input wire logic done,
	input wire logic [15:0] ea,
	input wire logic [15:0] operand,
	input wire logic pc_we,
	input wire logic [15:0] pc_value
);
	import eag_pkg::*;
	eag_mode_type mode_r;
	logic [7:0] prev_r;
	logic [7:0] last_r;
	logic [7:0] hi_r;
	logic ack_r;
	wire logic take = in_valid && in_ready && ce;
	wire logic [15:0] two = {prev_r, last_r};
	wire logic [15:0] sx = {{8{last_r[7]}}, last_r};
	// Mode kept past done, as the next start may come at done
	always_ff @(posedge clk) begin
		if (reset) mode_r <= EAG_M_INH;
		else if (start && !busy && ce) mode_r <= mode;
	end
	always_ff @(posedge clk) begin
		if (take) prev_r <= last_r;
		if (take) last_r <= in_byte;
		if (rd_req && rd_ack && !ack_r) hi_r <= rd_data;
		ack_r <= !reset && rd_req && (ack_r || (rd_ack && ce));
	end
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	chk_imm_value: assert property (
		done && mode_r inside {EAG_M_IMM8, EAG_M_IMM16} |-> operand ==
		(mode_r == EAG_M_IMM8 ? {8'h00, last_r} : two))
		else $error("immediate operand wrong");
	chk_ext_addr: assert property (
		done && mode_r == EAG_M_EXT |-> ea == two)
		else $error("extended address wrong");
	chk_dir_addr: assert property (
		done && mode_r == EAG_M_DIR |-> ea == {direct_page_register, last_r})
		else $error("direct address wrong");
	chk_short_branch: assert property (
		done && mode_r == EAG_M_BR8 |-> pc_value == pc + sx &&
		pc_we == $past(branch_cond))
		else $error("short branch wrong");
	chk_long_branch: assert property (
		done && mode_r == EAG_M_BR16 |-> pc_value == pc + two)
		else $error("long branch target wrong");
	chk_ind_hold: assert property (
		rd_req && !rd_ack |=> rd_req && $stable(rd_addr))
		else $error("indirect read dropped or moved");
	chk_ind_next: assert property (
		rd_req && rd_ack && !ack_r |=> rd_addr == $past(rd_addr) + 16'h0001)
		else $error("second indirect byte address wrong");
	chk_ind_result: assert property (
		rd_req && rd_ack && ack_r |=> done && !rd_req &&
		ea == {hi_r, $past(rd_data)})
		else $error("indirect result wrong");
	cov_ext: cover property (done && mode_r == EAG_M_EXT);
	cov_taken: cover property (pc_we);
	cov_ind: cover property (rd_req && rd_ack && ack_r);
endmodule : eag_props
bind eag_top eag_props i_props (.clk, .reset, .ce, .start, .mode,
	.branch_cond, .in_valid, .in_byte, .in_ready, .rd_req, .rd_addr,
	.rd_ack, .rd_data, .pc, .direct_page_register, .busy, .done, .ea,
	.operand, .pc_we, .pc_value);
`default_nettype wire

// file: verification/eag_far_model.sv
// Far side model: instruction byte stream and operand memory.
// Assumes the bench fills q before start and sets slow for stalls.
`default_nettype none
module eag_far_model (
	input wire logic clk,
	input wire logic in_ready,
	input wire logic rd_req,
	input wire logic [15:0] rd_addr,
	output logic in_valid,
	output logic [7:0] in_byte,
	output logic rd_ack,
	output logic [7:0] rd_data
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] q[$];
	logic slow = 1'b0;
	logic gap = 1'b0;
	logic [1:0] wait_r = 2'h0;
	function automatic logic [7:0] mem_byte(input logic [15:0] a);
		return a[15:8] ^ a[7:0] ^ 8'h3c;
	endfunction : mem_byte
	initial begin
		in_valid = 1'b0;
		in_byte = 8'h00;
		rd_ack = 1'b0;
		rd_data = 8'h00;
	end
	// A byte stays offered until taken; idle line toggles
	always @(posedge clk) begin
		if (!in_valid || in_ready) begin
			if (in_valid) void'(q.pop_front());
			gap <= slow && !gap;
			if (q.size() > 0 && !(slow && !gap)) begin
				in_valid <= 1'b1;
				in_byte <= q[0];
			end else begin
				in_valid <= 1'b0;
				in_byte <= ~in_byte;
			end
		end
	end
	// No ack in two neighbouring cycles: address moves after an ack
	always @(posedge clk) begin
		rd_ack <= 1'b0;
		rd_data <= ~rd_data;
		if (rd_req && !rd_ack && wait_r == 2'h0) begin
			rd_ack <= 1'b1;
			rd_data <= mem_byte(rd_addr);
			wait_r <= slow ? 2'h3 : 2'h0;
		end else if (rd_req && !rd_ack) begin
			wait_r <= wait_r - 2'h1;
		end
	end
endmodule : eag_far_model
`default_nettype wire

// file: verification/tb_effective_address_generator.sv
// Bench for the effective address generator top.
// Assumes the far model feeds bytes and answers indirect reads.
`default_nettype none
module tb_effective_address_generator;
	timeunit 1ns;
	timeprecision 1ns;
	import eag_pkg::*;
	logic clk = 1'b0;
	logic reset = 1'b1;
	logic ce = 1'b1;
	logic start = 1'b0;
	logic branch_cond = 1'b0;
	eag_mode_type mode = EAG_M_INH;
	logic [15:0] pc = 16'h4000, x_reg = 16'h1000, y_reg = 16'h2000;
	logic [15:0] u_reg = 16'h3000, s_reg = 16'hfff0;
	logic [7:0] a_reg = 8'h80, b_reg = 8'h7f, direct_page_register = 8'ha5;
	logic in_valid, in_ready, rd_req, rd_ack, busy, done, pc_we, ptr_we;
	logic idx_bad, pair_bad;
	logic [7:0] in_byte, rd_data, stack_mask;
	logic [15:0] rd_addr, ea, operand, pc_value, ptr_value;
	logic [1:0] ptr_sel;
	logic [3:0] pair_src, pair_dst, stack_bytes;
	int miscompares = 0;
	int cmp_count = 0;
	always #10 clk = ~clk;
	eag_top i_dut (.clk, .reset, .ce, .start, .mode, .branch_cond,
		.in_valid, .in_byte, .in_ready, .rd_req, .rd_addr, .rd_ack,
		.rd_data, .pc, .x_reg, .y_reg, .u_reg, .s_reg, .a_reg, .b_reg,
		.direct_page_register, .busy, .done, .ea, .operand, .pc_we,
		.pc_value, .ptr_we, .ptr_sel, .ptr_value, .idx_bad, .pair_src,
		.pair_dst, .pair_bad, .stack_mask, .stack_bytes);
	eag_far_model i_far (.clk, .in_ready, .rd_req, .rd_addr, .in_valid,
		.in_byte, .rd_ack, .rd_data);
	function automatic logic [7:0] mb(input logic [15:0] a);
		return a[15:8] ^ a[7:0] ^ 8'h3c;
	endfunction : mb
	task automatic chk(input string what, input logic [15:0] exp, got);
		cmp_count++;
		if (got !== exp) begin
			miscompares++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task automatic go(input eag_mode_type m, input int n,
		input logic [7:0] b0, b1, b2);
		logic [7:0] bs[3];
		int k;
		bs = '{b0, b1, b2};
		for (k = 0; k < n; k++) i_far.q.push_back(bs[k]);
		@(posedge clk);
		start <= 1'b1;
		mode <= m;
		@(posedge clk);
		start <= 1'b0;
		#1;
		// Bounded wait, a lost request must not hang the run
		for (k = 0; k < 40 && done !== 1'b1; k++) begin
			@(posedge clk);
			#1;
		end
		chk("done", 16'h0001, {15'h0, done});
	endtask : go
	task automatic ix(input logic [7:0] pb, o1, o2, input int n,
		input logic [15:0] exp, input logic pw, input logic [15:0] pv);
		go(EAG_M_IDX, n, pb, o1, o2);
		chk("idx ea", exp, ea);
		chk("idx bad", 16'h0, {15'h0, idx_bad});
		if (!pb[4] || !pb[7]) chk("ptr we", {15'h0, pw}, {15'h0, ptr_we});
		if (pw) chk("ptr", pv, ptr_value);
		if (pw) chk("sel", {14'h0, pb[6:5]}, {14'h0, ptr_sel});
	endtask : ix
	task automatic t_imm_ext_dir;
		go(EAG_M_IMM8, 1, 8'hf0, '0, '0);
		chk("imm8", 16'h00f0, operand);
		go(EAG_M_IMM16, 2, 8'h80, 8'h04, '0);
		chk("imm16", 16'h8004, operand);
		go(EAG_M_EXT, 2, 8'hff, 8'hfe, '0);
		chk("ext", 16'hfffe, ea);
		go(EAG_M_DIR, 1, 8'h00, '0, '0);
		chk("dir", 16'ha500, ea);
		go(EAG_M_INH, 0, '0, '0, '0);
	endtask : t_imm_ext_dir
	task automatic t_index;
		ix(8'h84, '0, '0, 1, 16'h1000, 1'b0, '0);
		ix(8'h3f, '0, '0, 1, 16'h1fff, 1'b0, '0);
		ix(8'hc8, 8'h80, '0, 2, 16'h2f80, 1'b0, '0);
		ix(8'he9, 8'h00, 8'h20, 3, 16'h0010, 1'b0, '0);
		ix(8'h86, '0, '0, 1, 16'h0f80, 1'b0, '0);
		ix(8'h85, '0, '0, 1, 16'h107f, 1'b0, '0);
		ix(8'h8b, '0, '0, 1, 16'h907f, 1'b0, '0);
		ix(8'h80, '0, '0, 1, 16'h1000, 1'b1, 16'h1001);
		ix(8'ha1, '0, '0, 1, 16'h2000, 1'b1, 16'h2002);
		ix(8'hc2, '0, '0, 1, 16'h2fff, 1'b1, 16'h2fff);
		ix(8'he3, '0, '0, 1, 16'hffee, 1'b1, 16'hffee);
		ix(8'h8c, 8'hfe, '0, 2, 16'h3ffe, 1'b0, '0);
		ix(8'hed, 8'h80, 8'h00, 3, 16'hc000, 1'b0, '0);
	endtask : t_index
	task automatic t_indirect;
		i_far.slow = 1'b1;
		ix(8'h94, '0, '0, 1, {mb(16'h1000), mb(16'h1001)}, 1'b0, '0);
		ix(8'hb1, '0, '0, 1, {mb(16'h2000), mb(16'h2001)}, 1'b1, 16'h2002);
		i_far.slow = 1'b0;
		ix(8'h9f, 8'h12, 8'h34, 3, {mb(16'h1234), mb(16'h1235)}, 1'b0, '0);
		ix(8'hdc, 8'h10, '0, 2, {mb(16'h4010), mb(16'h4011)}, 1'b0, '0);
	endtask : t_indirect
	// Illegal postbytes are flagged and still produce an address
	task automatic t_bad;
		go(EAG_M_IDX, 1, 8'h87, '0, '0);
		chk("bad code", 16'h0001, {15'h0, idx_bad});
		chk("bad ea", 16'h1000, ea);
		go(EAG_M_IDX, 1, 8'h90, '0, '0);
		chk("bad step", 16'h0001, {15'h0, idx_bad});
		chk("bad ind", {mb(16'h1000), mb(16'h1001)}, ea);
	endtask : t_bad
	// Start with enable low must be ignored; only while idle, as the
	// far model does not watch the enable
	task automatic t_hold;
		@(posedge clk);
		ce <= 1'b0;
		start <= 1'b1;
		mode <= EAG_M_EXT;
		repeat (3) @(posedge clk);
		ce <= 1'b1;
		start <= 1'b0;
		#1;
		chk("hold busy", 16'h0000, {15'h0, busy});
		chk("hold ready", 16'h0000, {15'h0, in_ready});
	endtask : t_hold
	task automatic t_branch;
		@(posedge clk);
		branch_cond <= 1'b1;
		go(EAG_M_BR8, 1, 8'h80, '0, '0);
		chk("pc we", 16'h0001, {15'h0, pc_we});
		chk("short", 16'h3f80, pc_value);
		go(EAG_M_BR16, 2, 8'h7f, 8'hff, '0);
		chk("long", 16'hbfff, pc_value);
		@(posedge clk);
		branch_cond <= 1'b0;
		go(EAG_M_BR16, 2, 8'h80, 8'h00, '0);
		chk("pc we", 16'h0000, {15'h0, pc_we});
		chk("long", 16'hc000, pc_value);
	endtask : t_branch
	task automatic t_pair;
		logic [3:0] s, d;
		for (int i = 0; i < 16; i++) begin
			s = 4'(i);
			d = ~s;
			go(EAG_M_REGPAIR, 1, {s, d}, '0, '0);
			chk("src", {12'h0, s}, {12'h0, pair_src});
			chk("dst", {12'h0, d}, {12'h0, pair_dst});
			chk("pair bad", {15'h0, !((s < 6 || (s > 7 && s < 12)) &&
				(d < 6 || (d > 7 && d < 12)))}, {15'h0, pair_bad});
		end
	endtask : t_pair
	task automatic t_stack;
		logic [7:0] ms[3] = '{8'hff, 8'h81, 8'h5a};
		logic [3:0] nb[3] = '{4'hc, 4'h3, 4'h6};
		for (int i = 0; i < 3; i++) begin
			go(EAG_M_STACK, 1, ms[i], '0, '0);
			chk("mask", {8'h0, ms[i]}, {8'h0, stack_mask});
			chk("bytes", {12'h0, nb[i]}, {12'h0, stack_bytes});
		end
	endtask : t_stack
	task automatic wrap_up;
		$display("comparisons %0d mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : wrap_up
	initial begin
		repeat (3) @(posedge clk);
		reset <= 1'b0;
		t_imm_ext_dir;
		t_hold;
		t_index;
		t_indirect;
		t_bad;
		t_branch;
		t_pair;
		t_stack;
		wrap_up;
	end
	// Whole run needs well under a thousand cycles
	initial begin
		#100000;
		miscompares++;
		wrap_up;
	end
endmodule : tb_effective_address_generator
`default_nettype wire
